// ===== core/ctm_core.v
`timescale 1ns/1ns
`include "ctm_defs.vh"

// Overview of operation
// [RULE_01] Up counter compared against comparators, raises interrupts
// [RULE_02] Separate interrupts for comparator A and P
// [RULE_03] Three-bit field selects count clock source
// [RULE_04] External pin counts on chosen edge
// [RULE_05] Compare match drives pin high, low, toggle
// [RULE_06] Edge-aligned PWM, duty or period adjustable
// [RULE_07] High byte direct, low byte via buffer
// [RULE_08] Compare low write fills buffer only
// [RULE_09] Compare high write copies buffer to low
// [RULE_10] High byte read captures low into buffer
// [RULE_11] Low byte read returns buffer contents
// [RULE_12] Software writes low first, reads high first
// [RULE_13] Compact variant: three modes, no single pulse
// [RULE_14] Periodic variant pin doubles as trigger
// [RULE_15] Software sets pin function and direction
// [RULE_16] 16-bit counter, A full, P top byte
// [RULE_17] Counter clears on enable, overflow, match only
// [RULE_18] Match flags sticky until software clears
module ctm_core (
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Timer pins
  input wire external_count_input_pin,
  input wire subsidiary_low_clock,
  output reg timer_output_pin,
  // Interrupt
  output reg irq
);

  // Mode-one-hot states of the output generator
  localparam ST_CMP = 3'b001;
  localparam ST_PWM = 3'b010;
  localparam ST_TMR = 3'b100;

  // Software-visible registers
  reg [7:0] ctrl0;
  reg [7:0] ctrl1;
  reg [15:0] compare_a_value;
  reg [7:0] compare_p_value;
  reg [7:0] hold_buf;
  reg [1:0] int_status;
  reg [1:0] int_enable;

  // Counting state
  reg [15:0] counter;
  reg [5:0] prescale;
  reg on_q;

  // Pin synchronisers plus one edge-history flop each
  reg pin_s1, pin_s2, pin_s3;
  reg sub_s1, sub_s2, sub_s3;

  // Output generator state
  reg out_level;
  reg [2:0] mode_state;

  // Combinational next values
  reg tick;
  reg [15:0] next_counter;
  reg next_out_level;
  reg [2:0] next_mode_state;
  reg [31:0] next_prdata;
  reg next_slverr;
  reg [7:0] next_hold_buf;

  // Control fields
  wire [2:0] ck_sel = ctrl0[`CTM_C0_CKSEL_HI:`CTM_C0_CKSEL_LO];
  wire run_on = ctrl0[`CTM_C0_ON];
  wire paused = ctrl0[`CTM_C0_PAUSE];
  wire [1:0] mode = ctrl1[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
  wire [1:0] io_sel = ctrl1[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
  wire on_rise = run_on & ~on_q;

  // Bus phases: buffer capture comes one edge before a write lands
  wire rd_prep = psel & penable & ~pready & ~pwrite;
  wire wr_go = psel & penable & pready & pwrite;
  wire wr_clr = wr_go & (paddr == `CTM_OFS_INT_CLR);

  // Matches look at the value the counter is about to take
  wire [15:0] cnt_inc = counter + 16'h0001;
  wire match_a = tick & (cnt_inc == compare_a_value);
  wire match_p = tick & (cnt_inc[7:0] == `CTM_RST_BYTE) & (cnt_inc[15:8] == compare_p_value);

  // The duty/period select swaps the roles of the two comparators
  wire period_hit = ctrl1[`CTM_C1_DPX] ? match_a : match_p;
  wire duty_hit = ctrl1[`CTM_C1_DPX] ? match_p : match_a;
  // Outside PWM the clear select picks the comparator that restarts
  wire clear_hit = ctrl1[`CTM_C1_CCLR] ? match_a : match_p;

  // Shared address decode for reads and writes
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `CTM_OFS_CTRL0) | (a == `CTM_OFS_CTRL1) |
                  (a == `CTM_OFS_CNT_LO) | (a == `CTM_OFS_CNT_HI) |
                  (a == `CTM_OFS_CMPA_LO) | (a == `CTM_OFS_CMPA_HI) |
                  (a == `CTM_OFS_CMPP) | (a == `CTM_OFS_INT_STAT) |
                  (a == `CTM_OFS_INT_CLR) | (a == `CTM_OFS_INT_EN);
    end
  endfunction

  // Edge of a synchronised line, taken between its last two flops
  function edge_of;
    input now;
    input was;
    input want_rise;
    begin
      edge_of = want_rise ? (now & ~was) : (~now & was);
    end
  endfunction

  // Pin inputs pass three flops; edges are read from the second and third
  // Only the second flop reads the first, so a metastable sample never reaches logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_s3 <= 1'b0;
    end else begin
      pin_s1 <= external_count_input_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      sub_s1 <= subsidiary_low_clock;
      sub_s2 <= sub_s1;
      sub_s3 <= sub_s2;
    end
  end

  // Free-running prescaler; the high clock is pclk itself here
  // Not restarted with the counter, so the first divided tick may come early
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 6'h00;
    end else begin
      prescale <= prescale + 6'h01;
    end
  end

  // Count enable per selected source; pause holds the count only
  always @* begin
    case (ck_sel) // [RULE_03]
      `CTM_CK_SYS4: tick = ((prescale & `CTM_DIV4_MASK) == `CTM_DIV4_MASK);
      `CTM_CK_SYS: tick = 1'b1;
      `CTM_CK_H16: tick = ((prescale & `CTM_DIV16_MASK) == `CTM_DIV16_MASK);
      `CTM_CK_H64: tick = (prescale == `CTM_DIV64_MASK);
      `CTM_CK_SUB0, `CTM_CK_SUB1: tick = edge_of(sub_s2, sub_s3, 1'b1);
      `CTM_CK_PIN_RISE: tick = edge_of(pin_s2, pin_s3, 1'b1); // [RULE_04]
      `CTM_CK_PIN_FALL: tick = edge_of(pin_s2, pin_s3, 1'b0); // [RULE_04] [RULE_14]
      default: tick = 1'b0;
    endcase
    tick = tick & run_on & ~paused;
  end

  // Counter: no load path from software at all
  always @* begin
    next_counter = counter;
    if (on_rise) begin
      next_counter = `CTM_RST_WORD; // [RULE_17]
    end else if (tick) begin
      next_counter = cnt_inc; // [RULE_01] [RULE_16] wraps to zero on overflow
      if (mode == `CTM_MODE_PWM) begin
        // PWM period comparator always restarts the cycle
        if (period_hit) begin
          next_counter = `CTM_RST_WORD; // [RULE_06] [RULE_17]
        end
      end else if (clear_hit) begin
        next_counter = `CTM_RST_WORD; // [RULE_17]
      end
    end
  end

  // Mode decode; the undefined encoding behaves as timer mode
  // Takes effect a cycle late, so software stops the timer before a change
  always @* begin
    case (mode) // [RULE_13]
      `CTM_MODE_CMP: next_mode_state = ST_CMP;
      `CTM_MODE_PWM: next_mode_state = ST_PWM;
      default: next_mode_state = ST_TMR;
    endcase
  end

  // Output level before polarity inversion
  always @* begin
    next_out_level = out_level;
    case (mode_state)
      ST_CMP: begin
        if (on_rise) begin
          next_out_level = ctrl1[`CTM_C1_OC];
        end else if (match_a) begin
          case (io_sel) // [RULE_05]
            `CTM_IO_LOW: next_out_level = 1'b0;
            `CTM_IO_HIGH: next_out_level = 1'b1;
            `CTM_IO_TOGGLE: next_out_level = ~out_level;
            default: next_out_level = out_level;
          endcase
        end
      end
      ST_PWM: begin
        // Active phase starts each period, ends at the duty match
        if (io_sel == `CTM_IO_NONE) begin
          next_out_level = ~ctrl1[`CTM_C1_OC];
        end else if (io_sel == `CTM_IO_LOW) begin
          next_out_level = ctrl1[`CTM_C1_OC];
        end else if (on_rise) begin
          next_out_level = ctrl1[`CTM_C1_OC];
        end else if (period_hit) begin
          next_out_level = ctrl1[`CTM_C1_OC]; // [RULE_06]
        end else if (duty_hit) begin
          next_out_level = ~ctrl1[`CTM_C1_OC]; // [RULE_06]
        end
      end
      ST_TMR: next_out_level = 1'b0;
      default: next_out_level = 1'b0;
    endcase
  end

  // Timer state registers
  // The pin is registered again so it comes straight from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter <= `CTM_RST_WORD;
      on_q <= 1'b0;
      out_level <= 1'b0;
      mode_state <= ST_CMP;
      timer_output_pin <= 1'b0;
    end else begin
      counter <= next_counter;
      on_q <= run_on;
      out_level <= next_out_level;
      mode_state <= next_mode_state;
      timer_output_pin <= next_out_level ^ (ctrl1[`CTM_C1_POL] & (mode_state != ST_TMR));
    end
  end

  // Sticky flags: a match in the clearing cycle still sets
  // A lost single-cycle match would be invisible to software, so set wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status <= 2'b00;
      irq <= 1'b0;
    end else begin
      int_status[`CTM_INT_A] <= match_a |
        (int_status[`CTM_INT_A] & ~(wr_clr & pwdata[`CTM_INT_A])); // [RULE_02] [RULE_18]
      int_status[`CTM_INT_P] <= match_p |
        (int_status[`CTM_INT_P] & ~(wr_clr & pwdata[`CTM_INT_P])); // [RULE_02] [RULE_18]
      irq <= |(int_status & int_enable); // [RULE_01]
    end
  end

  // Read data and buffer capture are prepared one edge before pready
  always @* begin
    next_prdata = 32'h00000000;
    next_hold_buf = hold_buf;
    next_slverr = ~is_mapped(paddr);
    case (paddr)
      `CTM_OFS_CTRL0: next_prdata[7:0] = ctrl0;
      `CTM_OFS_CTRL1: next_prdata[7:0] = ctrl1;
      `CTM_OFS_CNT_LO: next_prdata[7:0] = hold_buf; // [RULE_11]
      `CTM_OFS_CNT_HI: begin
        next_prdata[7:0] = counter[15:8]; // [RULE_07]
        next_hold_buf = counter[7:0]; // [RULE_10]
      end
      `CTM_OFS_CMPA_LO: next_prdata[7:0] = hold_buf; // [RULE_11]
      `CTM_OFS_CMPA_HI: begin
        next_prdata[7:0] = compare_a_value[15:8]; // [RULE_07]
        next_hold_buf = compare_a_value[7:0]; // [RULE_10]
      end
      `CTM_OFS_CMPP: next_prdata[7:0] = compare_p_value;
      `CTM_OFS_INT_STAT: next_prdata[1:0] = int_status;
      `CTM_OFS_INT_EN: next_prdata[1:0] = int_enable;
      default: next_prdata = 32'h00000000;
    endcase
  end

  // APB slave: one wait state on every transfer
  // Read data stays put across writes and idle cycles until the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        pslverr <= next_slverr;
        if (!pwrite) begin
          prdata <= next_prdata;
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Software-written registers and the low-byte buffer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0 <= `CTM_RST_BYTE;
      ctrl1 <= `CTM_RST_BYTE;
      compare_a_value <= `CTM_RST_WORD;
      compare_p_value <= `CTM_RST_BYTE;
      hold_buf <= `CTM_RST_BYTE;
      int_enable <= 2'b00;
    end else begin
      if (rd_prep) begin
        hold_buf <= next_hold_buf; // [RULE_10] [RULE_12]
      end
      if (wr_go) begin
        case (paddr)
          `CTM_OFS_CTRL0: ctrl0 <= pwdata[7:0] & `CTM_C0_MASK;
          `CTM_OFS_CTRL1: ctrl1 <= pwdata[7:0];
          // Low write only parks the byte; live compare unchanged
          `CTM_OFS_CMPA_LO: hold_buf <= pwdata[7:0]; // [RULE_08] [RULE_12]
          `CTM_OFS_CMPA_HI: compare_a_value <= {pwdata[7:0], hold_buf}; // [RULE_09]
          `CTM_OFS_CMPP: compare_p_value <= pwdata[7:0]; // [RULE_16]
          `CTM_OFS_INT_EN: int_enable <= pwdata[1:0];
          default: int_enable <= int_enable;
        endcase
      end
    end
  end

endmodule // ctm_core

// ===== shared/ctm_defs.vh
`ifndef CTM_DEFS_VH
`define CTM_DEFS_VH

// Register byte offsets
`define CTM_OFS_CTRL0 8'h00
`define CTM_OFS_CTRL1 8'h04
`define CTM_OFS_CNT_LO 8'h08
`define CTM_OFS_CNT_HI 8'h0c
`define CTM_OFS_CMPA_LO 8'h10
`define CTM_OFS_CMPA_HI 8'h14
`define CTM_OFS_CMPP 8'h18
`define CTM_OFS_INT_STAT 8'h1c
`define CTM_OFS_INT_CLR 8'h20
`define CTM_OFS_INT_EN 8'h24

// Control 0 fields
`define CTM_C0_PAUSE 7
`define CTM_C0_CKSEL_HI 6
`define CTM_C0_CKSEL_LO 4
`define CTM_C0_ON 3
`define CTM_C0_MASK 8'hf8

// Control 1 fields
`define CTM_C1_MODE_HI 7
`define CTM_C1_MODE_LO 6
`define CTM_C1_IO_HI 5
`define CTM_C1_IO_LO 4
`define CTM_C1_OC 3
`define CTM_C1_POL 2
`define CTM_C1_DPX 1
`define CTM_C1_CCLR 0

// Operating modes
`define CTM_MODE_CMP 2'h0
`define CTM_MODE_PWM 2'h2
`define CTM_MODE_TMR 2'h3

// Output pin actions
`define CTM_IO_NONE 2'h0
`define CTM_IO_LOW 2'h1
`define CTM_IO_HIGH 2'h2
`define CTM_IO_TOGGLE 2'h3
`define CTM_IO_PWM 2'h2

// Count clock choices
`define CTM_CK_SYS4 3'h0
`define CTM_CK_SYS 3'h1
`define CTM_CK_H16 3'h2
`define CTM_CK_H64 3'h3
`define CTM_CK_SUB0 3'h4
`define CTM_CK_SUB1 3'h5
`define CTM_CK_PIN_RISE 3'h6
`define CTM_CK_PIN_FALL 3'h7

// Prescaler terminal values
`define CTM_DIV4_MASK 6'h03
`define CTM_DIV16_MASK 6'h0f
`define CTM_DIV64_MASK 6'h3f

// Interrupt bits
`define CTM_INT_A 0
`define CTM_INT_P 1

// Reset values
`define CTM_RST_BYTE 8'h00
`define CTM_RST_WORD 16'h0000

`endif

// ===== verif/ctm_core_properties.sv
`timescale 1ns/1ns
module ctm_core_properties (
  // Bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pins
  input wire external_count_input_pin,
  input wire subsidiary_low_clock,
  input wire timer_output_pin,
  input wire irq
);
  // One domain for every check
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_ready_late: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready timing");
  a_err_ready: assert property (pslverr |-> pready) else $error("error alone");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 0)
    else $error("refused read data");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 0)
    else $error("upper bits set");
  a_data_hold: assert property ($changed(prdata) |-> $past(psel && !pwrite))
    else $error("read data moved");
  a_irq_fall: assert property ($fell(irq) |-> $past(pready && pwrite, 2))
    else $error("irq fell alone");
endmodule // ctm_core_properties

// ===== verif/ctm_core_tb_top.sv
`timescale 1ns/1ns
`include "ctm_defs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module ctm_core_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev, sub, pin, irq, err;
  logic [7:0] paddr, h;
  logic [31:0] pwdata, prdata, r;
  int errors, check_count, base;
  ctm_core dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .external_count_input_pin(ev), .subsidiary_low_clock(sub), .timer_output_pin(pin), .irq
  );
  ctm_pin_model pm (.clk(pclk), .out_pin(pin), .ev, .sub);
  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // One transfer, held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK($sformatf("reg %h", a), {24'h000000, e}, r)
  endtask
  // High byte first, then buffered low byte
  task automatic cnt(input logic [15:0] e);
    apb(1'b0, `CTM_OFS_CNT_HI, 8'h00);
    h = r[7:0];
    apb(1'b0, `CTM_OFS_CNT_LO, 8'h00);
    `CHK("counter", e, {h, r[7:0]})
  endtask
  task automatic t_regs();
    `CHK("pin", 1'b0, pin)
    rd(`CTM_OFS_INT_STAT, 8'h00);
    apb(1'b1, 8'h40, 8'h5a);
    `CHK("slverr", 1'b1, err)
    rd(8'h40, 8'h00);
    `CHK("slverr rd", 1'b1, err)
    apb(1'b1, `CTM_OFS_CTRL0, 8'hff);
    rd(`CTM_OFS_CTRL0, 8'hf8);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `CTM_OFS_CTRL1, {m[1:0], 6'h00});
      rd(`CTM_OFS_CTRL1, {m[1:0], 6'h00});
    end
  endtask
  task automatic t_buffer();
    apb(1'b1, `CTM_OFS_CMPA_LO, 8'h34);
    rd(`CTM_OFS_CMPA_HI, 8'h00);
    rd(`CTM_OFS_CMPA_LO, 8'h00);
    apb(1'b1, `CTM_OFS_CMPA_LO, 8'h34);
    apb(1'b1, `CTM_OFS_CMPA_HI, 8'h12);
    rd(`CTM_OFS_CMPA_HI, 8'h12);
    rd(`CTM_OFS_CMPA_LO, 8'h34);
    apb(1'b1, `CTM_OFS_CMPA_LO, 8'h03);
    apb(1'b1, `CTM_OFS_CMPA_HI, 8'h00);
  endtask
  task automatic t_events();
    apb(1'b1, `CTM_OFS_CTRL0, 8'h00);
    apb(1'b1, `CTM_OFS_CTRL1, 8'hc0);
    apb(1'b1, `CTM_OFS_CTRL0, 8'h68);
    pm.pulse(5);
    cnt(16'h0005);
    apb(1'b1, `CTM_OFS_CTRL0, 8'h00);
    apb(1'b1, `CTM_OFS_CTRL0, 8'h78);
    cnt(16'h0000);
    pm.pulse(2);
    cnt(16'h0002);
  endtask
  task automatic t_clk();
    for (int s = 0; s < 6; s++) begin
      apb(1'b1, `CTM_OFS_CTRL0, 8'h00);
      apb(1'b1, `CTM_OFS_CTRL0, {1'b0, s[2:0], 4'h8});
      repeat (150) @(posedge pclk);
      apb(1'b1, `CTM_OFS_CTRL0, {1'b0, s[2:0], 4'h0});
      apb(1'b0, `CTM_OFS_CNT_HI, 8'h00);
      h = r[7:0];
      apb(1'b0, `CTM_OFS_CNT_LO, 8'h00);
      `CHK("counting", 1'b1, ({h, r[7:0]} != 16'h0000))
    end
  endtask
  task automatic t_match();
    apb(1'b1, `CTM_OFS_CTRL0, 8'h00);
    apb(1'b1, `CTM_OFS_CTRL1, 8'h21);
    apb(1'b1, `CTM_OFS_INT_CLR, 8'h03);
    apb(1'b1, `CTM_OFS_INT_EN, 8'h03);
    apb(1'b1, `CTM_OFS_CTRL0, 8'h68);
    pm.pulse(3);
    `CHK("pin high", 1'b1, pin)
    rd(`CTM_OFS_INT_STAT, 8'h01);
    `CHK("irq", 1'b1, irq)
    cnt(16'h0000);
    apb(1'b1, `CTM_OFS_INT_EN, 8'h00);
    rd(`CTM_OFS_INT_STAT, 8'h01);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, `CTM_OFS_CTRL0, 8'h00);
    apb(1'b1, `CTM_OFS_CTRL1, 8'h31);
    apb(1'b1, `CTM_OFS_CTRL0, 8'h68);
    rd(`CTM_OFS_CTRL1, 8'h31);
    `CHK("pin initial", 1'b0, pin)
    pm.pulse(3);
    `CHK("toggle 1", 1'b1, pin)
    pm.pulse(3);
    `CHK("toggle 2", 1'b0, pin)
    apb(1'b1, `CTM_OFS_INT_CLR, 8'h01);
    rd(`CTM_OFS_INT_STAT, 8'h00);
    apb(1'b1, `CTM_OFS_CMPP, 8'h01);
    apb(1'b1, `CTM_OFS_CTRL0, 8'h00);
    apb(1'b1, `CTM_OFS_CTRL1, 8'h00);
    apb(1'b1, `CTM_OFS_INT_EN, 8'h02);
    apb(1'b1, `CTM_OFS_CTRL0, 8'h18);
    repeat (300) @(posedge pclk);
    rd(`CTM_OFS_CNT_HI, 8'h00);
    rd(`CTM_OFS_INT_STAT, 8'h03);
    `CHK("irq p", 1'b1, irq)
    apb(1'b1, `CTM_OFS_INT_CLR, 8'h03);
    rd(`CTM_OFS_INT_EN, 8'h02);
    `CHK("irq cleared", 1'b0, irq)
  endtask
  // P sets a 256 count period, A a 64 count duty
  task automatic t_pwm();
    apb(1'b1, `CTM_OFS_CTRL0, 8'h00);
    apb(1'b1, `CTM_OFS_CMPA_LO, 8'h40);
    apb(1'b1, `CTM_OFS_CMPA_HI, 8'h00);
    apb(1'b1, `CTM_OFS_CTRL1, 8'ha8);
    apb(1'b1, `CTM_OFS_CTRL0, 8'h18);
    repeat (300) @(posedge pclk);
    base = pm.highs;
    repeat (512) @(posedge pclk);
    `CHK("pwm high", 128, pm.highs - base)
    // A sets a 1024 count period, P a 256 count duty, pin inverted
    apb(1'b1, `CTM_OFS_CTRL0, 8'h00);
    apb(1'b1, `CTM_OFS_CMPA_LO, 8'h00);
    apb(1'b1, `CTM_OFS_CMPA_HI, 8'h04);
    apb(1'b1, `CTM_OFS_CTRL1, 8'hae);
    apb(1'b1, `CTM_OFS_CTRL0, 8'h18);
    repeat (1100) @(posedge pclk);
    base = pm.highs;
    repeat (1024) @(posedge pclk);
    `CHK("pwm inverted", 768, pm.highs - base)
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_buffer();
    t_events();
    t_clk();
    t_match();
    t_pwm();
    test_done();
  end
  // Watchdog, well past the few thousand cycles needed
  initial begin
    #60000;
    errors++;
    test_done();
  end
endmodule // ctm_core_tb_top
bind ctm_core ctm_core_properties chk (.*);

// ===== verif/ctm_pin_model.sv
`timescale 1ns/1ns
module ctm_pin_model (
  // Clock
  input wire clk,
  // Pins
  input wire out_pin,
  output reg ev,
  output reg sub
);
  int highs;
  // Event line idles low between pulses
  initial begin
    ev = 1'b0;
    sub = 1'b0;
    highs = 0;
  end
  // Slow clock locked to clk so windows repeat run to run
  always begin
    repeat (5) @(posedge clk);
    sub <= ~sub;
  end
  // Load side counts high cycles for duty checks
  always @(posedge clk) begin
    if (out_pin === 1'b1) highs <= highs + 1;
  end
  // Event source, pin used as a plain input
  task automatic pulse(input int n);
    repeat (n) begin
      ev <= 1'b1;
      repeat (4) @(posedge clk);
      ev <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // ctm_pin_model
